// file: rtl/vtc_device.sv
// controller end: transfer blocking, transfer/output-enable, arbitration, divider
`timescale 1ns/100ps
`include "vtc_consts.svh"
module vtc_device
   import vtc_pkg::*;
#(
   parameter logic [3:0] PORTB_CYCLES = `VTC_PORTB_CYCLES,
   parameter logic [3:0] RAS_LOW_CYCLES = `VTC_RAS_LOW_CYCLES,
   parameter logic [3:0] PRECHARGE_CYCLES = `VTC_PRECHARGE_CYCLES
) (
   input wire logic rst,
   vtc_link_if.device link,
   input wire logic delay_line_clock,
   input wire logic [`VTC_DIV_W-1:0] divisor_program_bits,
   input wire logic portb_request,
   input wire logic refresh_request,
   input wire logic write_indicator_n,
   input wire logic early_cas_option_n,
   input wire logic column_strobe_n,
   input wire logic row_strobe_n,
   output logic portb_grant,
   output logic refresh_grant,
   output logic wait_n,
   output logic transfer_acknowledge_n,
   output logic delay_reference
);
   // ---------------------------------------------------------------
   // transfer blocking and transfer/output-enable
   // ---------------------------------------------------------------
   logic block_ff, nxt_block;
   logic [2:0] edge_cnt_ff, nxt_edge_cnt;
   logic timeout_ff, nxt_timeout;
   logic load_busy_ff, nxt_load_busy;
   logic lapse_ff, nxt_lapse;
   logic strobe_low;
   logic xfer_drive_low;
   logic read_follow;

   assign strobe_low = ~link.shift_load_strobe_n;

   // next values; link signals are same-clock logic so no synchroniser
   always_comb begin
      nxt_edge_cnt = edge_cnt_ff;
      nxt_timeout = timeout_ff;
      if (!strobe_low) begin
         nxt_edge_cnt = 3'h0;
         nxt_timeout = 1'b0;
      end else if (!timeout_ff) begin
         nxt_edge_cnt = edge_cnt_ff + 3'h1;
         nxt_timeout = (edge_cnt_ff + 3'h1) == `VTC_XFER_TIMEOUT_EDGES;
      end
      // latch a short pulse; hold until four edges after the strobe fell
      nxt_lapse = lapse_ff | (nxt_timeout & ~timeout_ff);
      nxt_block = block_ff;
      if (!link.advance_load_request_n) begin
         nxt_block = 1'b1;
      end else if (nxt_lapse) begin
         nxt_block = 1'b0;
      end
      // a request held past the fourth edge frees the block when it rises
      if (!nxt_block) begin
         nxt_lapse = 1'b0;
      end
      // the load access lasts until the row strobe is back up
      nxt_load_busy = strobe_low | (load_busy_ff & ~row_strobe_n);
   end

   // registers hold through a stopped clock, no dynamic state
   always_ff @(posedge link.sys_clk or posedge rst) begin
      if (rst) begin
         block_ff <= 1'b0;
         edge_cnt_ff <= 3'h0;
         timeout_ff <= 1'b0;
         load_busy_ff <= 1'b0;
         lapse_ff <= 1'b0;
      end else begin
         block_ff <= nxt_block;
         edge_cnt_ff <= nxt_edge_cnt;
         timeout_ff <= nxt_timeout;
         load_busy_ff <= nxt_load_busy;
         lapse_ff <= nxt_lapse;
      end
   end

   // output must react without a clock edge, so it is gated, not registered
   assign xfer_drive_low = strobe_low & ~timeout_ff;
   assign read_follow = ~strobe_low & ~load_busy_ff & write_indicator_n
                        & early_cas_option_n & ~column_strobe_n;
   assign link.transfer_output_enable_n = ~(xfer_drive_low | read_follow);

   // ---------------------------------------------------------------
   // port B / refresh arbitration on the system clock
   // ---------------------------------------------------------------
   vtc_arb_state_t state_ff, nxt_state;
   logic [3:0] timer_ff, nxt_timer;
   logic portb_pend_ff, nxt_portb_pend;
   logic refresh_pend_ff, nxt_refresh_pend;
   logic portb_take, refresh_take;
   logic portb_grant_ff, refresh_grant_ff, wait_n_ff, ack_n_ff;
   logic nxt_portb_grant, nxt_refresh_grant, nxt_wait_n, nxt_ack_n;

   // requests are taken as synchronous to sys_clk
   always_comb begin
      nxt_state = state_ff;
      nxt_timer = timer_ff;
      portb_take = 1'b0;
      refresh_take = 1'b0;
      unique case (state_ff)
         VTC_ARB_IDLE: begin
            // a blocked request simply waits here
            if (!block_ff && portb_pend_ff) begin
               portb_take = 1'b1;
               nxt_state = VTC_ARB_PORTB;
               nxt_timer = PORTB_CYCLES - 4'h1;
            end else if (!block_ff && refresh_pend_ff) begin
               refresh_take = 1'b1;
               nxt_state = VTC_ARB_REFRESH;
               nxt_timer = RAS_LOW_CYCLES - 4'h1;
            end
         end
         VTC_ARB_PORTB, VTC_ARB_REFRESH: begin
            if (timer_ff == 4'h0) begin
               nxt_state = VTC_ARB_PRECHARGE;
               nxt_timer = PRECHARGE_CYCLES - 4'h1;
            end else begin
               nxt_timer = timer_ff - 4'h1;
            end
         end
         VTC_ARB_PRECHARGE: begin
            if (timer_ff == 4'h0) begin
               nxt_state = VTC_ARB_IDLE;
            end else begin
               nxt_timer = timer_ff - 4'h1;
            end
         end
      endcase
      // a new request in the taking cycle is kept, set beats clear
      nxt_portb_pend = portb_request | (portb_pend_ff & ~portb_take);
      nxt_refresh_pend = refresh_request | (refresh_pend_ff & ~refresh_take);
      nxt_portb_grant = nxt_state == VTC_ARB_PORTB;
      nxt_refresh_grant = nxt_state == VTC_ARB_REFRESH;
      // wait extends from each rising edge until port B is granted
      nxt_wait_n = ~(nxt_portb_pend & ~nxt_portb_grant);
      nxt_ack_n = ~nxt_portb_grant;
   end

   always_ff @(posedge link.sys_clk or posedge rst) begin
      if (rst) begin
         state_ff <= VTC_ARB_IDLE;
         timer_ff <= 4'h0;
         portb_pend_ff <= 1'b0;
         refresh_pend_ff <= 1'b0;
         portb_grant_ff <= 1'b0;
         refresh_grant_ff <= 1'b0;
         wait_n_ff <= 1'b1;
         ack_n_ff <= 1'b1;
      end else begin
         state_ff <= nxt_state;
         timer_ff <= nxt_timer;
         portb_pend_ff <= nxt_portb_pend;
         refresh_pend_ff <= nxt_refresh_pend;
         portb_grant_ff <= nxt_portb_grant;
         refresh_grant_ff <= nxt_refresh_grant;
         wait_n_ff <= nxt_wait_n;
         ack_n_ff <= nxt_ack_n;
      end
   end

   assign portb_grant = portb_grant_ff;
   assign refresh_grant = refresh_grant_ff;
   assign wait_n = wait_n_ff;
   assign transfer_acknowledge_n = ack_n_ff;

   // ---------------------------------------------------------------
   // delay line reference divider, own clock domain
   // ---------------------------------------------------------------
   logic [`VTC_DIV_W-1:0] div_sync1_ff, div_sync2_ff;
   logic [`VTC_DIV_W:0] div_cnt_ff, nxt_div_cnt;
   logic [`VTC_DIV_W:0] div_total;
   logic ref_ff, nxt_ref;

   // divisor bits are static straps, two flops then the counter
   // codes 0..7 give divide by 3..10, so 6 to 20 MHz in 2 MHz steps all reach 2 MHz
   always_comb begin
      div_total = {1'b0, div_sync2_ff} + `VTC_DIV_BASE;
      nxt_div_cnt = div_cnt_ff + 4'h1;
      if (div_cnt_ff >= div_total - 4'h1) begin
         nxt_div_cnt = 4'h0;
      end
      // high for the lower half of each divided period
      nxt_ref = div_cnt_ff < {1'b0, div_total[`VTC_DIV_W:1]};
   end

   always_ff @(posedge delay_line_clock or posedge rst) begin
      if (rst) begin
         div_sync1_ff <= `VTC_DIV_RESET;
         div_sync2_ff <= `VTC_DIV_RESET;
         div_cnt_ff <= 4'h0;
         ref_ff <= 1'b0;
      end else begin
         div_sync1_ff <= divisor_program_bits;
         div_sync2_ff <= div_sync1_ff;
         div_cnt_ff <= nxt_div_cnt;
         ref_ff <= nxt_ref;
      end
   end

   assign delay_reference = ref_ff;
endmodule

// file: rtl/vtc_consts.svh
// timing counts and field widths for the transfer cycle control ends
`ifndef VTC_CONSTS_SVH
`define VTC_CONSTS_SVH
`define VTC_SYS_CLK_MHZ 125
`define VTC_XFER_TIMEOUT_EDGES 3'h4
`define VTC_CNT_W 4
`define VTC_PORTB_CYCLES 4'h4
`define VTC_RAS_LOW_CYCLES 4'h6
`define VTC_PRECHARGE_CYCLES 4'h3
`define VTC_DIV_W 3
`define VTC_DIV_BASE 4'h3
`define VTC_DIV_RESET 3'h6
`define VTC_HOST_LEAD_CYCLES 4'h8
`define VTC_HOST_HOLD_CYCLES 4'h6
`endif

// file: rtl/vtc_pkg.sv
// types shared by the transfer cycle control ends
package vtc_pkg;
   typedef enum logic [1:0] {
      VTC_ARB_IDLE = 2'b00,
      VTC_ARB_PORTB = 2'b01,
      VTC_ARB_REFRESH = 2'b10,
      VTC_ARB_PRECHARGE = 2'b11
   } vtc_arb_state_t;
   typedef enum logic [1:0] {
      VTC_HOST_IDLE = 2'b00,
      VTC_HOST_LEAD = 2'b01,
      VTC_HOST_HOLD = 2'b10
   } vtc_host_state_t;
endpackage

// file: rtl/vtc_link_if.sv
// link between the transfer requester and the controller
`timescale 1ns/100ps
interface vtc_link_if (
   input wire logic sys_clk
);
   logic advance_load_request_n;
   logic shift_load_strobe_n;
   logic transfer_output_enable_n;
   modport device (
      input sys_clk,
      input advance_load_request_n,
      input shift_load_strobe_n,
      output transfer_output_enable_n
   );
   modport host (
      input sys_clk,
      output advance_load_request_n,
      output shift_load_strobe_n,
      input transfer_output_enable_n
   );
endinterface

// file: rtl/vtc_host.sv
// requester end: issues the load request and the shift-load strobe
`timescale 1ns/100ps
`include "vtc_consts.svh"
module vtc_host
   import vtc_pkg::*;
#(
   parameter logic [3:0] LEAD_CYCLES = `VTC_HOST_LEAD_CYCLES,
   parameter logic [3:0] HOLD_CYCLES = `VTC_HOST_HOLD_CYCLES,
   parameter bit PULSE_REQUEST = 1'b1
) (
   input wire logic rst,
   vtc_link_if.host link,
   input wire logic start_transfer,
   output logic busy,
   output logic done
);
   // ---------------------------------------------------------------
   // transfer sequencer
   // ---------------------------------------------------------------
   vtc_host_state_t state_ff, nxt_state;
   logic [3:0] cnt_ff, nxt_cnt;
   logic req_n_ff, nxt_req_n, strobe_n_ff, nxt_strobe_n, done_ff, nxt_done;
   logic busy_ff, nxt_busy;

   // lead time lets running accesses and refresh finish
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_req_n = 1'b1;
      nxt_strobe_n = 1'b1;
      nxt_done = 1'b0;
      unique case (state_ff)
         VTC_HOST_IDLE: begin
            if (start_transfer) begin
               nxt_state = VTC_HOST_LEAD;
               nxt_cnt = LEAD_CYCLES - 4'h1;
               nxt_req_n = 1'b0;
            end
         end
         VTC_HOST_LEAD: begin
            // either a one-cycle pulse or held through the transfer
            nxt_req_n = PULSE_REQUEST;
            if (cnt_ff == 4'h0) begin
               nxt_state = VTC_HOST_HOLD;
               nxt_cnt = HOLD_CYCLES - 4'h1;
               nxt_strobe_n = 1'b0;
            end else begin
               nxt_cnt = cnt_ff - 4'h1;
            end
         end
         VTC_HOST_HOLD: begin
            nxt_req_n = PULSE_REQUEST;
            nxt_strobe_n = 1'b0;
            if (cnt_ff == 4'h0) begin
               nxt_state = VTC_HOST_IDLE;
               nxt_strobe_n = 1'b1;
               nxt_req_n = 1'b1;
               nxt_done = 1'b1;
            end else begin
               nxt_cnt = cnt_ff - 4'h1;
            end
         end
         default: begin
            nxt_state = VTC_HOST_IDLE;
         end
      endcase
      // registered so the status output carries no decode glitch
      nxt_busy = nxt_state != VTC_HOST_IDLE;
   end

   // all link outputs come from flops on sys_clk
   always_ff @(posedge link.sys_clk or posedge rst) begin
      if (rst) begin
         state_ff <= VTC_HOST_IDLE;
         cnt_ff <= 4'h0;
         req_n_ff <= 1'b1;
         strobe_n_ff <= 1'b1;
         done_ff <= 1'b0;
         busy_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         req_n_ff <= nxt_req_n;
         strobe_n_ff <= nxt_strobe_n;
         done_ff <= nxt_done;
         busy_ff <= nxt_busy;
      end
   end

   assign link.advance_load_request_n = req_n_ff;
   assign link.shift_load_strobe_n = strobe_n_ff;
   assign busy = busy_ff;
   assign done = done_ff;
endmodule

// file: bench/vtc_link_chk.sv
// concurrent checks on the transfer link between requester and controller
`timescale 1ns/100ps
module vtc_link_chk #(
   parameter int LEAD_CYCLES = 8
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic advance_load_request_n,
   input wire logic shift_load_strobe_n,
   input wire logic transfer_output_enable_n
);
   // ----------------------------------------
   // strobe-low edge count
   // ----------------------------------------
   logic [2:0] low_edges_ff;
   logic [2:0] nxt_low_edges;
   // saturates so a long strobe hold cannot wrap back into the window
   always_comb begin
      nxt_low_edges = low_edges_ff;
      if (shift_load_strobe_n)
         nxt_low_edges = 3'h0;
      else if (low_edges_ff != 3'h7)
         nxt_low_edges = low_edges_ff + 3'h1;
   end
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst)
         low_edges_ff <= 3'h0;
      else
         low_edges_ff <= nxt_low_edges;
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // request pulse then the strobe fall of the same transfer
   sequence req_pulse_s;
      $fell(advance_load_request_n) ##1 advance_load_request_n;
   endsequence
   sequence strobe_fall_s;
      ##7 $fell(shift_load_strobe_n);
   endsequence
   oe_low_a: assert property (
      !shift_load_strobe_n && low_edges_ff < 3'h4 |-> !transfer_output_enable_n)
      else $error("output enable not low during strobe");
   oe_timeout_a: assert property (
      !shift_load_strobe_n && low_edges_ff >= 3'h4 |-> transfer_output_enable_n)
      else $error("output enable low past the fourth edge");
   oe_release_a: assert property (
      $rose(shift_load_strobe_n) |-> transfer_output_enable_n)
      else $error("output enable not released with strobe");
   oe_fresh_a: assert property (
      $fell(shift_load_strobe_n) |-> !transfer_output_enable_n ##1 !transfer_output_enable_n)
      else $error("timeout count not fresh on new strobe");
   strobe_hold_a: assert property (
      $fell(shift_load_strobe_n) |-> (!shift_load_strobe_n) [*6] ##1 shift_load_strobe_n)
      else $error("strobe low length wrong");
   req_lead_a: assert property (
      $fell(shift_load_strobe_n) |-> !$past(advance_load_request_n, LEAD_CYCLES))
      else $error("strobe fell without request lead");
   req_pulse_a: assert property (
      $fell(advance_load_request_n) |=> advance_load_request_n)
      else $error("request not a one cycle pulse");
   host_walk_a: assert property (req_pulse_s |-> strobe_fall_s)
      else $error("strobe fall not at lead after request");
endmodule

// file: bench/tb_top.sv
// self-checking bench: requester and controller joined over the transfer link
`timescale 1ns/100ps
module tb_top;
   import vtc_pkg::*;
   // ----------------------------------------
   // stimulus and instances
   // ----------------------------------------
   logic sys_clk = 1'b0;
   logic delay_line_clock = 1'b0;
   logic rst = 1'b1;
   logic start_transfer = 1'b0;
   logic portb_request = 1'b0;
   logic refresh_request = 1'b0;
   logic write_indicator_n = 1'b1;
   logic early_cas_option_n = 1'b0;
   logic column_strobe_n = 1'b1;
   logic row_strobe_n = 1'b1;
   logic [2:0] divisor_code = 3'h7;
   logic portb_grant, refresh_grant, wait_n, transfer_acknowledge_n, delay_reference;
   logic busy, done;
   int bad_count = 0;
   int samples_checked = 0;
   int n;
   int hi;
   always #4 sys_clk = ~sys_clk;
   // own 20 MHz clock; code 7 divides by ten down to 2 MHz
   always #25 delay_line_clock = ~delay_line_clock;
   vtc_link_if link_if (.sys_clk(sys_clk));
   vtc_host vtc_host_i (.rst(rst), .link(link_if.host), .start_transfer(start_transfer),
      .busy(busy), .done(done));
   vtc_device vtc_device_i (.rst(rst), .link(link_if.device),
      .delay_line_clock(delay_line_clock), .divisor_program_bits(divisor_code),
      .portb_request(portb_request), .refresh_request(refresh_request),
      .write_indicator_n(write_indicator_n), .early_cas_option_n(early_cas_option_n),
      .column_strobe_n(column_strobe_n), .row_strobe_n(row_strobe_n),
      .portb_grant(portb_grant), .refresh_grant(refresh_grant), .wait_n(wait_n),
      .transfer_acknowledge_n(transfer_acknowledge_n), .delay_reference(delay_reference));
   vtc_link_chk #(.LEAD_CYCLES(8)) vtc_link_chk_i (.sys_clk(sys_clk), .rst(rst),
      .advance_load_request_n(link_if.advance_load_request_n),
      .shift_load_strobe_n(link_if.shift_load_strobe_n),
      .transfer_output_enable_n(link_if.transfer_output_enable_n));
   task automatic check(input string what, input logic exp, input logic got);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // one-cycle pulse: 0 start, 1 port b, 2 refresh; returns at the sampling edge
   task automatic pulse(input int which);
      @(posedge sys_clk);
      start_transfer <= (which == 0);
      portb_request <= (which == 1);
      refresh_request <= (which == 2);
      @(posedge sys_clk);
      start_transfer <= 1'b0;
      portb_request <= 1'b0;
      refresh_request <= 1'b0;
   endtask
   task automatic wait_grant(input bit refresh, input int limit);
      n = 0;
      while ((refresh ? refresh_grant : portb_grant) !== 1'b1) begin
         @(posedge sys_clk);
         n++;
         if (n > limit) begin
            check("grant wait", 1'b1, 1'b0);
            report_and_stop();
         end
      end
   endtask
   // watchdog so a hung handshake still reaches the verdict
   initial begin
      #200000;
      check("run time", 1'b1, 1'b0);
      report_and_stop();
   end
   initial begin
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      // plain port b access with the link idle
      pulse(1);
      #1 check("wait_n pending", 1'b0, wait_n);
      @(posedge sys_clk);
      #1 check("portb_grant", 1'b1, portb_grant);
      check("transfer_acknowledge_n", 1'b0, transfer_acknowledge_n);
      repeat (4) @(posedge sys_clk);
      #1 check("portb_grant end", 1'b0, portb_grant);
      repeat (8) @(posedge sys_clk);
      // requests raised inside the transfer must wait, then both be served
      pulse(0);
      early_cas_option_n <= 1'b1;
      column_strobe_n <= 1'b0;
      #1 check("busy", 1'b1, busy);
      pulse(1);
      pulse(2);
      for (int i = 0; i < 8; i++) begin
         @(posedge sys_clk);
         #1 check("grant while blocked", 1'b0, portb_grant | refresh_grant);
      end
      // read follow is set up, yet the timed-out load keeps the output high
      check("oe after timeout", 1'b1, link_if.transfer_output_enable_n);
      check("strobe still low", 1'b0, link_if.shift_load_strobe_n);
      wait_grant(1'b0, 40);
      check("refresh after port b", 1'b0, refresh_grant);
      #1 check("done", 1'b1, done);
      check("busy end", 1'b0, busy);
      wait_grant(1'b1, 40);
      repeat (12) @(posedge sys_clk);
      // read follow once no load is running
      early_cas_option_n <= 1'b1;
      write_indicator_n <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         @(posedge sys_clk);
         column_strobe_n <= i[0];
         #1 check("oe follows column", i[0], link_if.transfer_output_enable_n);
      end
      @(posedge sys_clk);
      write_indicator_n <= 1'b0;
      #1 check("oe held on write", 1'b1, link_if.transfer_output_enable_n);
      // divide by ten: five of every ten delay clocks high
      hi = 0;
      repeat (40) begin
         @(posedge delay_line_clock);
         #1 hi += (delay_reference === 1'b1);
      end
      check("delay_reference div10", 1'b1, hi == 20);
      @(posedge delay_line_clock);
      divisor_code <= 3'h0;
      repeat (8) @(posedge delay_line_clock);
      // smallest code divides by three: one of every three high
      hi = 0;
      repeat (30) begin
         @(posedge delay_line_clock);
         #1 hi += (delay_reference === 1'b1);
      end
      check("delay_reference div3", 1'b1, hi == 10);
      report_and_stop();
   end
endmodule
